// ### hw/sswo_top.sv
`include "sswo_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module sswo_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire sswo_pkg::sswo_evt_t evt,
  input wire sswo_pkg::sswo_mode_t mode,
  input wire sswo_pkg::sswo_q_t p1_q,
  input wire sswo_pkg::sswo_q_t p2_q,
  input wire logic p1_rx_active,
  output logic p1_frame_drop,
  output logic [1:0] tx_fifo_flush,
  output logic [1:0] rx_fifo_flush,
  output logic next_port2,
  output logic next_high
);
  import sswo_pkg::*;

  sswo_state_t st_r;
  sswo_state_t st_nxt;

  logic hit;
  logic wr_hit;
  logic p1_rdy;
  logic p2_rdy;
  logic sel_port2;
  logic sel_high;
  logic tx_rdy_set;
  logic gap_short;
  logic p1_start;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] live_v;
  logic [31:0] word_v;

  // ----------------------------------------
  // receive readiness and port choice
  // ----------------------------------------
  always_comb begin
    // store and forward needs a whole frame, cut through a threshold or an end
    if (mode.cut_through) begin
      p1_rdy = p1_q.thresh_hit || p1_q.eof_seen;
      p2_rdy = p2_q.thresh_hit || p2_q.eof_seen;
    end else begin
      p1_rdy = p1_q.hi_frames || p1_q.lo_frames;
      p2_rdy = p2_q.hi_frames || p2_q.lo_frames;
    end
  end

  sswo_rxsel u_rxsel (
    .clk(clk),
    .rst_n(rst_n),
    .p1_q(p1_q),
    .p2_q(p2_q),
    .p1_rdy(p1_rdy),
    .p2_rdy(p2_rdy),
    .low_first(mode.low_priority_first_select),
    .sel_port2(sel_port2),
    .sel_high(sel_high)
  );

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  assign hit = (reg_addr == `SSWO_ADDR);
  assign wr_hit = reg_wr && hit;
  assign p1_start = p1_rx_active && !st_r.p1_act;
  assign gap_short = p1_start && (st_r.gap_cnt < mode.p1_gap_threshold);
  // with the empty control set, completion alone is not enough
  assign tx_rdy_set = evt.tx_frame_done &&
                      (!mode.tx_rdy_on_empty || evt.tx_fifo_empty);

  always_comb begin
    set_v = `SSWO_ZERO;
    set_v[`SSWO_B_TS_B] = evt.ts_slot_b;
    set_v[`SSWO_B_TS_A] = evt.ts_slot_a;
    set_v[`SSWO_B_TX_ECC] = |evt.tx_ecc_err;
    set_v[`SSWO_B_RX_ECC] = |evt.rx_ecc_err;
    // crc check only exists in the generic serial protocol
    set_v[`SSWO_B_SPI_CRC] = evt.spi_crc_err && mode.generic_spi;
    set_v[`SSWO_B_P1_GAP] = gap_short;
    set_v[`SSWO_B_TX_RDY] = tx_rdy_set;
  end

  // only sticky bits respond to writes; zeros and read-only bits drop out
  assign clr_v = wr_hit ? (reg_wdata & `SSWO_W1C_MASK) : `SSWO_ZERO;

  always_comb begin
    live_v = `SSWO_ZERO;
    // the phy summary has no clear here; the host clears it in the phy
    live_v[`SSWO_B_P2_PHY] = evt.p2_phy_irq;
    live_v[`SSWO_B_P2_HI] = p2_q.hi_frames && mode.generic_spi;
    live_v[`SSWO_B_P2_RDY] = p2_rdy && mode.generic_spi;
    live_v[`SSWO_B_P1_HI] = p1_q.hi_frames && mode.generic_spi;
    live_v[`SSWO_B_P1_RDY] = p1_rdy && mode.generic_spi;
  end

  assign word_v = (st_r.sticky & `SSWO_W1C_MASK) | live_v;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // set wins over a clear landing in the same cycle
    st_nxt.sticky = ((st_r.sticky & ~clr_v) | set_v) & `SSWO_W1C_MASK;

    // gap counter saturates so a long idle never wraps into a short gap
    st_nxt.p1_act = p1_rx_active;
    if (p1_rx_active) begin
      st_nxt.gap_cnt = `SSWO_GAP_ZERO;
    end else if (st_r.gap_cnt != `SSWO_GAP_MAX) begin
      st_nxt.gap_cnt = st_r.gap_cnt + `SSWO_GAP_ONE;
    end
    if (gap_short) begin
      st_nxt.p1_drop = 1'b1;
    end else if (!p1_rx_active) begin
      st_nxt.p1_drop = 1'b0;
    end

    // flush strobes to the fifo controllers: each error input registered, one cycle late and as long as it lasts
    st_nxt.tx_flush = evt.tx_ecc_err;
    st_nxt.rx_flush = evt.rx_ecc_err;

    st_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      st_nxt.rdata = hit ? word_v : `SSWO_ZERO;
    end

    st_nxt.next_port2 = sel_port2;
    st_nxt.next_high = sel_high;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.sticky <= `SSWO_RESET;
      st_r.gap_cnt <= `SSWO_GAP_MAX;
      st_r.p1_act <= 1'b0;
      st_r.p1_drop <= 1'b0;
      st_r.rdata <= `SSWO_RESET;
      st_r.rvalid <= 1'b0;
      st_r.tx_flush <= 2'h0;
      st_r.rx_flush <= 2'h0;
      st_r.next_port2 <= 1'b0;
      st_r.next_high <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  // a dropped frame is flagged from its first beat: gap_short is ored in unregistered
  // beside p1_drop, so the start beat is gated too
  assign p1_frame_drop = st_r.p1_drop || gap_short;
  assign tx_fifo_flush = st_r.tx_flush;
  assign rx_fifo_flush = st_r.rx_flush;
  assign next_port2 = st_r.next_port2;
  assign next_high = st_r.next_high;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ts_slots;
    @(posedge clk) disable iff (!rst_n)
      (evt.ts_slot_a || evt.ts_slot_b)
      |=> (st_r.sticky[`SSWO_B_TS_A] || !$past(evt.ts_slot_a))
          && (st_r.sticky[`SSWO_B_TS_B] || !$past(evt.ts_slot_b));
  endproperty
  a_ts_slots: assert property (p_ts_slots)
    else $error("timestamp slot flag not set");

  property p_phy_live;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && hit) |=> (reg_rdata[`SSWO_B_P2_PHY] == $past(evt.p2_phy_irq));
  endproperty
  a_phy_live: assert property (p_phy_live)
    else $error("phy summary bit does not follow source");

  property p_hi_live;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && hit && mode.generic_spi)
      |=> (reg_rdata[`SSWO_B_P2_HI] == $past(p2_q.hi_frames));
  endproperty
  a_hi_live: assert property (p_hi_live)
    else $error("port 2 high priority bit wrong");

  property p_sf_ready;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && hit && mode.generic_spi && !mode.cut_through
       && !p1_q.hi_frames && !p1_q.lo_frames)
      |=> !reg_rdata[`SSWO_B_P1_RDY];
  endproperty
  a_sf_ready: assert property (p_sf_ready)
    else $error("port 1 ready with no frame queued");

  property p_tx_flush;
    @(posedge clk) disable iff (!rst_n)
      evt.tx_ecc_err[0]
      |=> (tx_fifo_flush[0] && st_r.sticky[`SSWO_B_TX_ECC])
          ##1 (tx_fifo_flush[0] == $past(evt.tx_ecc_err[0]));
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("tx ecc error without flush");

  property p_rx_flush;
    @(posedge clk) disable iff (!rst_n)
      $rose(evt.rx_ecc_err[1])
      |=> (rx_fifo_flush[1] && st_r.sticky[`SSWO_B_RX_ECC]);
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("rx ecc error without clear");

  property p_crc_gate;
    @(posedge clk) disable iff (!rst_n)
      (!mode.generic_spi && !st_r.sticky[`SSWO_B_SPI_CRC])
      |=> !st_r.sticky[`SSWO_B_SPI_CRC];
  endproperty
  a_crc_gate: assert property (p_crc_gate)
    else $error("crc flag set outside generic mode");

  property p_gap_drop;
    @(posedge clk) disable iff (!rst_n)
      (p1_rx_active && !st_r.p1_act && st_r.gap_cnt < mode.p1_gap_threshold)
      |-> p1_frame_drop ##1 st_r.sticky[`SSWO_B_P1_GAP];
  endproperty
  a_gap_drop: assert property (p_gap_drop)
    else $error("short gap frame not dropped");

  property p_tx_rdy;
    @(posedge clk) disable iff (!rst_n)
      (evt.tx_frame_done && mode.tx_rdy_on_empty && !evt.tx_fifo_empty
       && !st_r.sticky[`SSWO_B_TX_RDY])
      |=> !st_r.sticky[`SSWO_B_TX_RDY];
  endproperty
  a_tx_rdy: assert property (p_tx_rdy)
    else $error("tx ready set with fifo not empty");

  property p_zero_keep;
    @(posedge clk) disable iff (!rst_n)
      (wr_hit && !reg_wdata[`SSWO_B_TX_RDY] && st_r.sticky[`SSWO_B_TX_RDY])
      |=> st_r.sticky[`SSWO_B_TX_RDY];
  endproperty
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero write cleared a sticky flag");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      reg_rvalid |-> (reg_rdata[31:22] == 10'h000) && (reg_rdata[16:13] == 4'h0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_addr;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && !hit) |=> (reg_rdata == 32'h00000000);
  endproperty
  a_addr: assert property (p_addr)
    else $error("other address returned the status word");

endmodule

`default_nettype wire

// ### shared/sswo_cfg.svh
`ifndef SSWO_CFG_SVH
`define SSWO_CFG_SVH

// ----------------------------------------
// register placement
// ----------------------------------------
`define SSWO_ADDR 8'h09
`define SSWO_RESET 32'h00000000
`define SSWO_ZERO 32'h00000000

// ----------------------------------------
// bit positions of the status word
// ----------------------------------------
`define SSWO_B_TS_B 21
`define SSWO_B_TS_A 20
`define SSWO_B_P2_PHY 19
`define SSWO_B_P2_HI 18
`define SSWO_B_P2_RDY 17
`define SSWO_B_TX_ECC 12
`define SSWO_B_RX_ECC 11
`define SSWO_B_SPI_CRC 10
`define SSWO_B_P1_GAP 8
`define SSWO_B_P1_HI 5
`define SSWO_B_P1_RDY 4
`define SSWO_B_TX_RDY 3

// sticky bits that a host one clears
`define SSWO_W1C_MASK 32'h00301d08

// ----------------------------------------
// gap counter
// ----------------------------------------
`define SSWO_GAP_W 8
`define SSWO_GAP_MAX 8'hff
`define SSWO_GAP_ONE 8'h01
`define SSWO_GAP_ZERO 8'h00

`endif

// ### shared/sswo_pkg.sv
package sswo_pkg;

  // queue state of one receive port
  typedef struct packed {
    logic hi_frames;
    logic lo_frames;
    logic thresh_hit;
    logic eof_seen;
  } sswo_q_t;

  // static controls from the rest of the switch
  typedef struct packed {
    logic generic_spi;
    logic cut_through;
    logic low_priority_first_select;
    logic tx_rdy_on_empty;
    logic [7:0] p1_gap_threshold;
  } sswo_mode_t;

  // event pulses and levels feeding the word
  typedef struct packed {
    logic ts_slot_a;
    logic ts_slot_b;
    logic p2_phy_irq;
    logic [1:0] tx_ecc_err;
    logic [1:0] rx_ecc_err;
    logic spi_crc_err;
    logic tx_frame_done;
    logic tx_fifo_empty;
  } sswo_evt_t;

  typedef struct packed {
    logic [31:0] sticky;
    logic [7:0] gap_cnt;
    logic p1_act;
    logic p1_drop;
    logic [31:0] rdata;
    logic rvalid;
    logic [1:0] tx_flush;
    logic [1:0] rx_flush;
    logic next_port2;
    logic next_high;
  } sswo_state_t;

endpackage

// ### hw/sswo_rxsel.sv
`timescale 1ns/10ps
`default_nettype none

module sswo_rxsel (
  input wire logic clk,
  input wire logic rst_n,
  input wire sswo_pkg::sswo_q_t p1_q,
  input wire sswo_pkg::sswo_q_t p2_q,
  input wire logic p1_rdy,
  input wire logic p2_rdy,
  input wire logic low_first,
  output logic sel_port2,
  output logic sel_high
);
  import sswo_pkg::*;

  logic hi_sel;
  logic lo_sel;

  always_comb begin
    // port choice: a lone ready port wins, then a lone high flag
    if (p1_rdy && p2_rdy) begin
      sel_port2 = p2_q.hi_frames && !p1_q.hi_frames;
    end else begin
      sel_port2 = p2_rdy && !p1_rdy;
    end
    hi_sel = sel_port2 ? p2_q.hi_frames : p1_q.hi_frames;
    lo_sel = sel_port2 ? p2_q.lo_frames : p1_q.lo_frames;
    // both queues busy: the control flips the default order
    if (hi_sel && lo_sel) begin
      sel_high = !low_first;
    end else begin
      sel_high = hi_sel;
    end
  end

  property p_prio_order;
    @(posedge clk) disable iff (!rst_n)
      (!sel_port2 && p1_rdy && p1_q.hi_frames && p1_q.lo_frames)
      |-> (sel_high == !low_first);
  endproperty
  a_prio_order: assert property (p_prio_order)
    else $error("queue order ignores low priority first control");

  property p_port_pick;
    @(posedge clk) disable iff (!rst_n)
      (p1_rdy && p2_rdy && p2_q.hi_frames && !p1_q.hi_frames)
      |-> sel_port2;
  endproperty
  a_port_pick: assert property (p_port_pick)
    else $error("port 2 high priority frame not chosen");

endmodule

`default_nettype wire

// ### sim/sswo_host.sv
`timescale 1ns/10ps
`default_nettype none

module sswo_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
  end

  // ones clear sticky flags, zeros leave them alone
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released data no longer shows the last value
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rvalid === 1'b1 ? reg_rdata : 32'hdead_beef;
  endtask
endmodule

`default_nettype wire

// ### sim/switch_status_word_one_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sswo_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end

module switch_status_word_one_tb;
  import sswo_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  sswo_evt_t evt = '0;
  sswo_mode_t mode = '0;
  sswo_q_t p1_q = '0;
  sswo_q_t p2_q = '0;
  logic p1_rx_active = 1'b0;
  logic p1_frame_drop;
  logic [1:0] tx_fifo_flush;
  logic [1:0] rx_fifo_flush;
  logic next_port2;
  logic next_high;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [15:0] lf = 16'h1daf;
  int bp[6] = '{20, 21, 12, 11, 10, 3};

  always #10 clk = ~clk;

  sswo_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .evt(evt), .mode(mode), .p1_q(p1_q), .p2_q(p2_q),
    .p1_rx_active(p1_rx_active), .p1_frame_drop(p1_frame_drop),
    .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush),
    .next_port2(next_port2), .next_high(next_high));

  sswo_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic rdy(sswo_q_t q, logic ct);
    return ct ? (q.thresh_hit | q.eof_seen) : (q.hi_frames | q.lo_frames);
  endfunction

  // store and forward only: a lone ready port wins, then a lone high flag
  function automatic logic pick2(sswo_q_t a, sswo_q_t b);
    return !rdy(a, 1'b0) || (b.hi_frames && !a.hi_frames);
  endfunction

  function automatic logic first_hi(sswo_q_t q, logic lo_first);
    return q.hi_frames && !(lo_first && q.lo_frames);
  endfunction

  function automatic logic [31:0] live(sswo_q_t a, sswo_q_t b, sswo_mode_t m, logic phy);
    logic [31:0] w;
    w = 32'h0;
    w[19] = phy;
    if (m.generic_spi) begin
      w[18] = b.hi_frames;
      w[17] = rdy(b, m.cut_through);
      w[5] = a.hi_frames;
      w[4] = rdy(a, m.cut_through);
    end
    return w;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one event pulse from the table, levels kept
  task automatic pulse(int k);
    sswo_evt_t b;
    sswo_evt_t e;
    // levels are read at the edge so one set just before the call is kept
    @(posedge clk);
    b = evt;
    e = b;
    case (k)
      0: e.ts_slot_a = 1'b1;
      1: e.ts_slot_b = 1'b1;
      2: e.tx_ecc_err = 2'b01;
      3: e.rx_ecc_err = 2'b10;
      4: e.spi_crc_err = 1'b1;
      default: e.tx_frame_done = 1'b1;
    endcase
    evt <= e;
    @(posedge clk);
    evt <= b;
    #1;
    `CHK(tx_fifo_flush, (k == 2) ? 2'b01 : 2'b00)
    `CHK(rx_fifo_flush, (k == 3) ? 2'b10 : 2'b00)
  endtask

  task automatic frame(int idle, logic drop);
    repeat (idle) @(posedge clk);
    p1_rx_active <= 1'b1;
    #1;
    `CHK(p1_frame_drop, drop)
    repeat (3) @(posedge clk);
    p1_rx_active <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    mode.generic_spi <= 1'b1;
    u_host.rd(`SSWO_ADDR, d);
    `CHK(d, 32'h0)
    $display("test reset done");
    // ----------------------------------------
    // sticky flags: set, keep on zero write, clear on one
    // ----------------------------------------
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      u_host.rd(`SSWO_ADDR, d);
      `CHK(d, 32'h1 << bp[k])
      u_host.wr(`SSWO_ADDR, 32'h0);
      u_host.wr(8'h0a, 32'hffff_ffff);
      u_host.rd(8'h0a, d);
      `CHK(d, 32'h0)
      u_host.rd(`SSWO_ADDR, d);
      `CHK(d, 32'h1 << bp[k])
      u_host.wr(`SSWO_ADDR, 32'hffff_ffff);
      u_host.rd(`SSWO_ADDR, d);
      `CHK(d, 32'h0)
    end
    $display("test sticky done");
    mode.tx_rdy_on_empty <= 1'b1;
    pulse(5);
    u_host.rd(`SSWO_ADDR, d);
    `CHK(d, 32'h0)
    evt.tx_fifo_empty <= 1'b1;
    pulse(5);
    u_host.rd(`SSWO_ADDR, d);
    `CHK(d, 32'h8)
    u_host.wr(`SSWO_ADDR, 32'h8);
    mode.generic_spi <= 1'b0;
    pulse(4);
    u_host.rd(`SSWO_ADDR, d);
    `CHK(d, 32'h0)
    mode.generic_spi <= 1'b1;
    $display("test modes done");
    // ----------------------------------------
    // random live bits and next-frame choice
    // ----------------------------------------
    for (int i = 0; i < 40; i++) begin
      lf = nxt(lf);
      @(posedge clk);
      p1_q <= sswo_q_t'(lf[3:0]);
      p2_q <= sswo_q_t'(lf[7:4]);
      mode.cut_through <= lf[8];
      mode.low_priority_first_select <= lf[9];
      evt.p2_phy_irq <= lf[10];
      u_host.rd(`SSWO_ADDR, d);
      `CHK(d, live(p1_q, p2_q, mode, lf[10]))
      if (!lf[8] && (rdy(p1_q, 1'b0) || rdy(p2_q, 1'b0))) begin
        `CHK(next_port2, pick2(p1_q, p2_q))
        `CHK(next_high, pick2(p1_q, p2_q) ? first_hi(p2_q, lf[9]) :
          first_hi(p1_q, lf[9]))
      end
    end
    p1_q <= '0;
    p2_q <= '0;
    evt.p2_phy_irq <= 1'b0;
    $display("test live done");
    mode.p1_gap_threshold <= 8'h0a;
    frame(2, 1'b0);
    frame(3, 1'b1);
    u_host.rd(`SSWO_ADDR, d);
    `CHK(d, 32'h100)
    u_host.wr(`SSWO_ADDR, 32'h100);
    frame(30, 1'b0);
    $display("test gap done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
